// file: rtl/cssc_map.svh
// Purpose: constants of the core storage sequence control
// Assumes: 50 MHz pclk, one timing step per pclk
// Notes: offsets are byte addresses on APB
`ifndef CSSC_MAP_SVH
`define CSSC_MAP_SVH
`define CSSC_WORD_W        48
`define CSSC_ADDR_W        15
`define CSSC_RING_LEN      8
`define CSSC_LAST_STEP     6'd32
`define CSSC_READ_SET      6'd1
`define CSSC_READ_CLR      6'd10
`define CSSC_INH_SET       6'd13
`define CSSC_WRITE_SET     6'd15
`define CSSC_DRIVE_CLR     6'd24
`define CSSC_HOLD_CLR      6'd7
`define CSSC_HOLD_LOAD     6'd8
`define CSSC_DUMMY_SET     6'd11
`define CSSC_DUMMY_CLR     6'd42
`define CSSC_STEP_NS       200
`define CSSC_CLK_NS        20
`define CSSC_SAMPLE_NS     1600
`define CSSC_OFF_CTRL      12'h000
`define CSSC_OFF_STATUS    12'h004
`define CSSC_OFF_ADDR      12'h008
`define CSSC_OFF_HOLD_LO   12'h00C
`define CSSC_OFF_HOLD_HI   12'h010
`define CSSC_OFF_SRC       12'h014
`define CSSC_CTRL_START    0
`define CSSC_CTRL_WRITE    1
`define CSSC_CTRL_TOCTL    2
`endif

// file: rtl/cssc_pkg.sv
// Purpose: types of the core storage sequence control
// Assumes: cssc_map.svh holds the numbers
// Notes: none
package cssc_pkg;
	typedef enum logic [2:0] {
		CSSC_SRC_NEXT_INSTR,
		CSSC_SRC_OPERAND,
		CSSC_SRC_PROG_ADDR,
		CSSC_SRC_IO_CTRL,
		CSSC_SRC_AUX
	} cssc_src_t;
	typedef enum {CSSC_IDLE, CSSC_RUN} cssc_state_t;
	typedef struct packed {
		logic read_drive;
		logic write_drive;
		logic inhibit_drive;
		logic dummy_drive;
		logic hold_clear;
		logic hold_load;
		logic sense_to_exchange_pulse;
		logic sense_to_control_pulse;
	} cssc_drive_t;
endpackage : cssc_pkg

// file: rtl/cssc_seq.sv
// Purpose: storage reference start, timing ring, drives and bit plane control
// Assumes: one timing step per pclk; synchronous pins
// Notes: fault detector and resume pulses are not modelled
// Overview of operation
// - Sense amp bit enters sense rank only under the active quadrant read gate.
// - Hold clear empties hold register; hold load sets stages with sense ones.
// - Read references also pulse sense-to-exchange or sense-to-control transfer.
// - Hold load and transfers come about 1.2 us (six steps) after read drive begins.
// - Inhibit passes per bit only where the hold stage holds zero.
// - Only the selected quadrant inhibit generator is enabled.
// - Dummy load stays on except for zero hold bits in the dummy window.
// - Read drive first, then inhibit drive, then write drive.
// - Start loads the address register of the chosen unit, starts its sequence.
// - Requesting sequence chooses address source among three places.
// - Exactly one of five source flops is set per request.
// - Odd and even sequence controls are identical fixed series.
// - Timing pulses appear only in the window after start, then stop.
// - One pulse circulates through an eight-stage ring, one step apart.
// - Ring splits into two groups of four positions.
// - Rank one copies to rank two first half; rank two plus one loads rank one.
// - Four counts over four ring cycles give 32 steps after initial pulse.
// - Rank one stable in first half, rank two in second half.
// - Ranks decode one-hot and combine with ring groups into numbered pulses.
// - Read drive sets at pulse 1, clears at pulse 10.
// - Write drive sets at pulse 15, clears at pulse 24.
// - Inhibit drive sets at pulse 13, clears at pulse 24.
// - Hold clear pulse comes from timing pulse 7.
`timescale 1ns/1ns
`include "cssc_map.svh"
module cssc_seq
	import cssc_pkg::*;
(
	// APB
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Address sources
	input  wire logic [`CSSC_ADDR_W-1:0]  prog_ctrl_addr,
	input  wire logic [`CSSC_ADDR_W-1:0]  prog_addr,
	input  wire logic [`CSSC_ADDR_W-1:0]  io_ctrl_addr,
	// Bit plane
	input  wire logic [`CSSC_WORD_W-1:0]  sense_amp,
	input  wire logic [`CSSC_WORD_W-1:0]  exchange_word,
	input  wire logic [3:0]               quadrant_sel,
	output logic      [`CSSC_WORD_W-1:0]  hold_q,
	output logic      [`CSSC_WORD_W-1:0]  inhibit_bit,
	output logic      [3:0]               inhibit_gen_en,
	output logic      [`CSSC_WORD_W-1:0]  dummy_load_en,
	output logic      [`CSSC_ADDR_W-1:0]  even_addr_q,
	output logic      [`CSSC_ADDR_W-1:0]  odd_addr_q,
	output logic                          odd_sel_q,
	output cssc_drive_t                   drive
);
	localparam int SAMPLE_CYC = `CSSC_SAMPLE_NS / `CSSC_CLK_NS / (`CSSC_STEP_NS / `CSSC_CLK_NS);

	function automatic logic [3:0] dec2(input logic [1:0] v);
		dec2 = 4'h1 << v;
	endfunction : dec2

	cssc_state_t                state_q;
	logic [`CSSC_RING_LEN-1:0]  ring_q;
	logic [1:0]                 rank_one_q;
	logic [1:0]                 counter_rank_two_q;
	logic [5:0]                 step;
	logic                       step_vld;
	logic [5:0]                 tail_q;
	logic                       start_p;
	logic                       is_write_q;
	logic                       to_ctrl_q;
	logic [2:0]                 src_code_q;
	logic [4:0]                 src_ff_q;
	logic [`CSSC_ADDR_W-1:0]    ref_addr;
	logic [`CSSC_WORD_W-1:0]    sense_rank;
	logic                       apb_wr;
	logic                       busy;
	logic                       dummy_q;
	logic                       rd_q, wr_q, inh_q;

	assign apb_wr  = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign busy    = (state_q == CSSC_RUN) || dummy_q;
	assign start_p = apb_wr && paddr == `CSSC_OFF_CTRL && pwdata[`CSSC_CTRL_START] && !busy;

	always_comb begin
		pslverr = 1'b0;
		prdata  = 32'h0000_0000;
		case (paddr)
			`CSSC_OFF_CTRL:    prdata = {29'h0, to_ctrl_q, is_write_q, 1'b0};
			`CSSC_OFF_STATUS:  prdata = {16'h0, 4'h0, step, rank_one_q, counter_rank_two_q, 1'b0, busy};
			`CSSC_OFF_ADDR:    prdata = {16'h0, odd_sel_q, odd_sel_q ? odd_addr_q : even_addr_q};
			`CSSC_OFF_HOLD_LO: prdata = hold_q[31:0];
			`CSSC_OFF_HOLD_HI: prdata = {16'h0, hold_q[47:32]};
			`CSSC_OFF_SRC:     prdata = {24'h0, src_ff_q, src_code_q};
			default:           pslverr = psel && penable;
		endcase
	end


	// Source code from software: 0 next instr, 1 operand, 2 prog addr, 3 io, 4 aux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			src_code_q <= 3'h0;
		else if (apb_wr && paddr == `CSSC_OFF_SRC)
			src_code_q <= pwdata[2:0];
	end

	// Direction and target latched only on an accepted start
	// A start refused while busy leaves the running reference untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			is_write_q <= 1'b0;
			to_ctrl_q  <= 1'b0;
		end else if (start_p) begin
			is_write_q <= pwdata[`CSSC_CTRL_WRITE];
			to_ctrl_q  <= pwdata[`CSSC_CTRL_TOCTL];
		end
	end


	// One-hot source flop chosen per request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			src_ff_q <= 5'h00;
		else if (start_p)
			src_ff_q <= (src_code_q > 3'd4) ? 5'h01 : 5'(5'h01 << src_code_q);
	end

	// Next instruction and prog addr from P, operand from U, io and aux flops from io control
	always_comb begin
		case (src_code_q)
			3'd1:    ref_addr = prog_ctrl_addr;
			3'd3:    ref_addr = io_ctrl_addr;
			3'd4:    ref_addr = io_ctrl_addr;
			default: ref_addr = prog_addr;
		endcase
	end


	// Address bit 0 picks the odd or even unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			odd_sel_q <= 1'b0;
		else if (start_p)
			odd_sel_q <= ref_addr[0];
	end

	// Each unit keeps its own address register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			even_addr_q <= '0;
		else if (start_p && !ref_addr[0])
			even_addr_q <= ref_addr;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			odd_addr_q <= '0;
		else if (start_p && ref_addr[0])
			odd_addr_q <= ref_addr;
	end


	// Both units share this one sequencer: identical series
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CSSC_IDLE;
		end else begin
			case (state_q)
				CSSC_IDLE: if (start_p) state_q <= CSSC_RUN;
				CSSC_RUN:  if (step_vld && step == `CSSC_LAST_STEP) state_q <= CSSC_IDLE;
				default:   state_q <= CSSC_IDLE;
			endcase
		end
	end

	// Ring position 0 marks pulse 0; one step per pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ring_q <= '0;
		else if (start_p)
			ring_q <= 8'h01;
		else if (state_q == CSSC_RUN && !(step_vld && step == `CSSC_LAST_STEP))
			ring_q <= {ring_q[6:0], ring_q[7]};
		else
			ring_q <= '0;
	end


	// Rank two takes rank one at ring position 1
	// Rank one is still stable there, so the copy never sees a half-changed count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			counter_rank_two_q <= 2'b00;
		else if (start_p)
			counter_rank_two_q <= 2'b00;
		else if (state_q == CSSC_RUN && ring_q[1])
			counter_rank_two_q <= rank_one_q;
	end

	// Rank one takes rank two plus one at ring position 5
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rank_one_q <= 2'b00;
		else if (start_p)
			rank_one_q <= 2'b00;
		else if (state_q == CSSC_RUN && ring_q[5])
			rank_one_q <= 2'(counter_rank_two_q + 2'b01);
	end

	// Ring one-hot to position index; position 0 also when the ring is empty
	function automatic logic [2:0] ring_pos(input logic [`CSSC_RING_LEN-1:0] r);
		ring_pos = 3'd0;
		for (int k = 1; k < `CSSC_RING_LEN; k++) begin
			if (r[k])
				ring_pos = 3'(k);
		end
	endfunction : ring_pos

	// Positions 1..4 read rank one, 5..7 and the closing position 0 read rank two
	always_comb begin
		logic [3:0] d1;
		logic [3:0] d2;
		logic [2:0] pos;
		d1       = dec2(rank_one_q);
		d2       = dec2(counter_rank_two_q);
		pos      = ring_pos(ring_q);
		step_vld = state_q == CSSC_RUN && ring_q != '0;
		step     = 6'd0;
		for (int g = 0; g < 4; g++) begin
			case (pos)
				3'd1, 3'd2, 3'd3, 3'd4: begin
					if (d1[g])
						step = 6'(g * 8 + int'(pos));
				end
				3'd5, 3'd6, 3'd7: begin
					if (d2[g])
						step = 6'(g * 8 + int'(pos));
				end
				default: begin
					if (d2[g])
						step = 6'(g * 8 + 8);
				end
			endcase
		end
		// Equal ranks at position 0 happen only at the initial pulse
		if (pos == 3'd0 && rank_one_q == counter_rank_two_q)
			step = 6'd0;
	end


	// Delay chain after pulse 32 makes pulse 42 for dummy drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tail_q <= 6'd0;
		else if (step_vld && step == `CSSC_LAST_STEP)
			tail_q <= 6'd33;
		else if (tail_q != 6'd0 && tail_q != `CSSC_DUMMY_CLR)
			tail_q <= 6'(tail_q + 6'd1);
		else
			tail_q <= 6'd0;
	end


	// True in the cycle of the numbered timing pulse n
	function automatic logic at_step(input logic vld, input logic [5:0] s, input logic [5:0] n);
		at_step = vld && s == n;
	endfunction : at_step

	// Read drive: clears the selected cores first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_q <= 1'b0;
		else if (at_step(step_vld, step, `CSSC_READ_SET))
			rd_q <= 1'b1;
		else if (at_step(step_vld, step, `CSSC_READ_CLR))
			rd_q <= 1'b0;
	end

	// Inhibit drive leads write drive so zero bits are covered from its start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			inh_q <= 1'b0;
		else if (at_step(step_vld, step, `CSSC_INH_SET))
			inh_q <= 1'b1;
		else if (at_step(step_vld, step, `CSSC_DRIVE_CLR))
			inh_q <= 1'b0;
	end

	// Write drive sets uninhibited cores to one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wr_q <= 1'b0;
		else if (at_step(step_vld, step, `CSSC_WRITE_SET))
			wr_q <= 1'b1;
		else if (at_step(step_vld, step, `CSSC_DRIVE_CLR))
			wr_q <= 1'b0;
	end

	// Dummy window outlives the ring; its end timing is not critical
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dummy_q <= 1'b0;
		else if (at_step(step_vld, step, `CSSC_DUMMY_SET))
			dummy_q <= 1'b1;
		else if (tail_q == `CSSC_DUMMY_CLR)
			dummy_q <= 1'b0;
	end


	// Sample point: read set step plus 1.6 us in ring steps, less one step
	logic hold_load_p;
	logic hold_clear_p;
	assign hold_clear_p = step_vld && step == `CSSC_HOLD_CLR;
	assign hold_load_p  = step_vld && step == 6'(`CSSC_READ_SET + SAMPLE_CYC - 1);

	always_comb begin
		drive                         = '0;
		drive.read_drive              = rd_q;
		drive.write_drive             = wr_q;
		drive.inhibit_drive           = inh_q;
		drive.dummy_drive             = dummy_q;
		drive.hold_clear              = hold_clear_p;
		drive.hold_load               = hold_load_p;
		drive.sense_to_exchange_pulse = hold_load_p && !is_write_q && !to_ctrl_q;
		drive.sense_to_control_pulse  = hold_load_p && !is_write_q && to_ctrl_q;
	end

	// Read gate opens on any selected quadrant; on writes the exchange word feeds the rank
	always_comb begin
		if (is_write_q)
			sense_rank = exchange_word;
		else if (rd_q && quadrant_sel != 4'h0)
			sense_rank = sense_amp;
		else
			sense_rank = '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_q <= '0;
		else if (hold_clear_p)
			hold_q <= '0;
		else if (hold_load_p)
			hold_q <= hold_q | sense_rank;
	end


	// Lowest set bit: a stray second quadrant bit can never enable two generators
	function automatic logic [3:0] lowest_one(input logic [3:0] v);
		lowest_one = v & 4'(~v + 4'h1);
	endfunction : lowest_one

	// Zero bits of hold pass inhibit; one quadrant generator only
	always_comb begin
		inhibit_bit    = '0;
		inhibit_gen_en = 4'h0;
		if (inh_q) begin
			inhibit_bit    = ~hold_q;
			inhibit_gen_en = lowest_one(quadrant_sel);
		end
	end

	// Dummy load stays on except for zero hold bits in the dummy window
	always_comb begin
		dummy_load_en = '1;
		if (dummy_q && busy)
			dummy_load_en = hold_q;
	end

endmodule : cssc_seq

// file: tb/cssc_seq_assertions.sv
// Purpose: timing and bit plane checks on cssc_seq ports
// Assumes: one timing step per pclk
// Notes: bound to every cssc_seq instance
`timescale 1ns/1ns
`include "cssc_map.svh"
module cssc_seq_assertions
	import cssc_pkg::*;
(
	// Clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// Bit plane
	input wire logic [3:0]              quadrant_sel,
	input wire logic [`CSSC_WORD_W-1:0] hold_q,
	input wire logic [`CSSC_WORD_W-1:0] inhibit_bit,
	input wire logic [3:0]              inhibit_gen_en,
	input wire logic [`CSSC_WORD_W-1:0] dummy_load_en,
	input wire cssc_drive_t             drive
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_read_span: assert property ($rose(drive.read_drive) |->
		drive.read_drive[*8] ##1 drive.read_drive ##1 !drive.read_drive) else $error("read drive span wrong");
	a_write_span: assert property ($rose(drive.write_drive) |->
		drive.write_drive[*8] ##1 drive.write_drive ##1 !drive.write_drive) else $error("write drive span wrong");
	a_inhibit_lead: assert property ($rose(drive.inhibit_drive) |-> ##2 $rose(drive.write_drive))
		else $error("write drive not two steps after inhibit");
	a_drive_end: assert property ($fell(drive.write_drive) |-> $fell(drive.inhibit_drive))
		else $error("inhibit and write drive end apart");
	a_read_first: assert property ($rose(drive.inhibit_drive) |->
		!drive.read_drive && $past(drive.read_drive, 4)) else $error("inhibit not after read drive");
	a_hold_steps: assert property ($rose(drive.read_drive) |->
		##5 drive.hold_clear ##1 drive.hold_load) else $error("hold clear or load misplaced");
	a_xfer_sample: assert property ((drive.sense_to_exchange_pulse || drive.sense_to_control_pulse) |->
		drive.hold_load && drive.read_drive) else $error("transfer pulse misplaced");
	a_inhibit_bits: assert property (inhibit_bit == (drive.inhibit_drive ? ~hold_q : '0))
		else $error("inhibit bits wrong");
	a_gen_select: assert property (inhibit_gen_en ==
		(drive.inhibit_drive ? (quadrant_sel & (~quadrant_sel + 4'h1)) : 4'h0)) else $error("generator select wrong");
	a_dummy_load: assert property (dummy_load_en ==
		(drive.dummy_drive ? hold_q : {`CSSC_WORD_W{1'b1}})) else $error("dummy load wrong");
endmodule : cssc_seq_assertions
bind cssc_seq cssc_seq_assertions u_chk (.pclk(pclk), .presetn(presetn), .quadrant_sel(quadrant_sel),
	.hold_q(hold_q), .inhibit_bit(inhibit_bit), .inhibit_gen_en(inhibit_gen_en),
	.dummy_load_en(dummy_load_en), .drive(drive));

// file: tb/cssc_core_model.sv
// Purpose: core plane and sense line model facing the sequence control
// Assumes: core_word is the stored word seen by the read drive
// Notes: sense lines show the inverse word outside read drive
`timescale 1ns/1ns
`include "cssc_map.svh"
module cssc_core_model
	import cssc_pkg::*;
(
	// Clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// Plane
	input wire cssc_drive_t             drive,
	input wire logic [`CSSC_WORD_W-1:0] inhibit_bit,
	input wire logic [`CSSC_WORD_W-1:0] core_word,
	output logic     [`CSSC_WORD_W-1:0] sense_amp,
	output logic     [`CSSC_WORD_W-1:0] restored
);
	// Inverse word drives the sense lines when read drive is off
	assign sense_amp = drive.read_drive ? core_word : ~core_word;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			restored <= '0;
		else if (drive.read_drive)
			restored <= '0;
		else if (drive.write_drive)
			restored <= ~inhibit_bit;
	end
endmodule : cssc_core_model

// file: tb/cssc_seq_test.sv
// Purpose: self-checking bench of cssc_seq over APB
// Assumes: pready answers at once, but the master still waits
// Notes: five references cover every address source
`timescale 1ns/1ns
`include "cssc_map.svh"
module cssc_seq_test;
	import cssc_pkg::*;
	logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, odd_sel_q;
	logic [11:0]             paddr;
	logic [31:0]             pwdata, prdata;
	logic [`CSSC_ADDR_W-1:0] prog_ctrl_addr, prog_addr, io_ctrl_addr, even_addr_q, odd_addr_q;
	logic [`CSSC_WORD_W-1:0] sense_amp, exchange_word, hold_q, inhibit_bit, dummy_load_en, core_word, restored;
	logic [3:0]              quadrant_sel, inhibit_gen_en;
	cssc_drive_t             drive;
	int                      err_total, checks;
	cssc_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prog_ctrl_addr(prog_ctrl_addr), .prog_addr(prog_addr), .io_ctrl_addr(io_ctrl_addr),
		.sense_amp(sense_amp), .exchange_word(exchange_word), .quadrant_sel(quadrant_sel), .hold_q(hold_q),
		.inhibit_bit(inhibit_bit), .inhibit_gen_en(inhibit_gen_en), .dummy_load_en(dummy_load_en),
		.even_addr_q(even_addr_q), .odd_addr_q(odd_addr_q), .odd_sel_q(odd_sel_q), .drive(drive));
	cssc_core_model u_core (.pclk(pclk), .presetn(presetn), .drive(drive), .inhibit_bit(inhibit_bit),
		.core_word(core_word), .sense_amp(sense_amp), .restored(restored));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic results();
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic chk(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: check %0d mismatched", $time, checks);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		#200000;
		err_total++;
		$display("unexpected at %0t: run timed out", $time);
		results();
	end
	initial begin
		logic [31:0]             r;
		logic                    e;
		logic [`CSSC_ADDR_W-1:0] a;
		logic [`CSSC_WORD_W-1:0] w;
		int                      n;
		err_total = 0;
		checks = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		prog_addr = 15'h0a2c;
		prog_ctrl_addr = 15'h1235;
		io_ctrl_addr = 15'h3ff1;
		exchange_word = '0;
		core_word = '0;
		quadrant_sel = 4'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(drive === '0 && (&dummy_load_en) === 1'b1 && hold_q === '0);
		apb(1'b0, 12'h0f0, 32'h0000_0000, r, e);
		chk(e === 1'b1 && r === 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			w = 48'h0f0f_5a5a_c3c3 << i;
			core_word <= w;
			quadrant_sel <= (i < 4) ? 4'(1 << i) : 4'h0;
			if (i == 4)
				w = '0;
			if (i == 2) begin
				exchange_word <= 48'h9abc_def0_1234;
				w = 48'h9abc_def0_1234;
			end
			a = (i == 1) ? prog_ctrl_addr : (i > 2) ? io_ctrl_addr : prog_addr;
			apb(1'b1, `CSSC_OFF_SRC, 32'(i), r, e);
			apb(1'b1, `CSSC_OFF_CTRL, (i == 2) ? 32'h0000_0003 : i[0] ? 32'h0000_0005 : 32'h0000_0001, r, e);
			n = 0;
			while (drive.inhibit_drive !== 1'b1 && n < 60) begin
				@(posedge pclk);
				n++;
			end
			chk(hold_q === w);
			chk(inhibit_bit === ~w && inhibit_gen_en === quadrant_sel);
			chk(dummy_load_en === w);
			// Start while busy must be dropped
			apb(1'b1, `CSSC_OFF_CTRL, 32'h0000_0001, r, e);
			n = 0;
			do begin
				apb(1'b0, `CSSC_OFF_STATUS, 32'h0000_0000, r, e);
				n++;
			end while (r[0] !== 1'b0 && n < 40);
			chk(n < 40 && restored === w);
			chk((odd_sel_q ? odd_addr_q : even_addr_q) === a && odd_sel_q === a[0]);
			apb(1'b0, `CSSC_OFF_SRC, 32'h0000_0000, r, e);
			chk(r[7:3] === 5'(1 << i));
		end
		results();
	end
endmodule : cssc_seq_test
